/* pxs_pkg.sv */
// Shared constants and helpers of the sensor register link.
`default_nettype none
package pxs_pkg;
  // ==========================================================================
  // Link addressing
  // Bus address of the device; the value is arbitrary.
  localparam logic [6:0] PXS_DEV_ADDR = 7'h2a;
  localparam logic       PXS_RW_WRITE = 1'b0;
  localparam logic       PXS_RW_READ  = 1'b1;

  // ==========================================================================
  // Register offsets and reset values
  localparam logic [7:0] PXS_OFS_STATUS = 8'h8e;
  localparam logic [7:0] PXS_OFS_MODTIM = 8'h8f;
  localparam logic [7:0] PXS_OFS_AMBIR  = 8'h90;
  localparam logic [7:0] PXS_MODTIM_RST = 8'h01;
  localparam logic [3:0] PXS_STATUS_RST = 4'h0;

  // ==========================================================================
  // Field positions
  localparam int PXS_ST_PROX  = 3;
  localparam int PXS_ST_ALS   = 2;
  localparam int PXS_ST_BELOW = 1;
  localparam int PXS_ST_ABOVE = 0;
  localparam int PXS_ST_W     = 4;
  localparam int PXS_DLY_LSB  = 5;
  localparam int PXS_DLY_W    = 3;
  localparam int PXS_FRQ_LSB  = 3;
  localparam int PXS_FRQ_W    = 2;
  localparam int PXS_DEAD_LSB = 0;
  localparam int PXS_DEAD_W   = 3;

  // ==========================================================================
  // Helpers
  // Address byte sent after a start: device address and direction bit.
  function automatic logic [7:0] pxs_addr_byte(input logic rw);
    return {PXS_DEV_ADDR, rw};
  endfunction

  // Register read decode; unmapped offsets read as zero.
  function automatic logic [7:0] pxs_read_reg(input logic [7:0] ofs,
                                              input logic [3:0] status,
                                              input logic [7:0] modtim,
                                              input logic [7:0] ambir);
    logic [7:0] v;
    v = 8'h00;
    unique case (ofs)
      PXS_OFS_STATUS: v = {4'h0, status};
      PXS_OFS_MODTIM: v = modtim;
      PXS_OFS_AMBIR:  v = ambir;
      default:        v = 8'h00;
    endcase
    return v;
  endfunction
endpackage
`default_nettype wire

/* pxs_link_if.sv */
// Byte-level serial register link between host controller and sensor.
`default_nettype none
interface pxs_link_if;
  // Host to device.
  logic       start;
  logic       stop;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  // Device to host.
  logic       ack_valid;
  logic       ack;
  logic       rvalid;
  logic [7:0] rdata;
  // Open-drain interrupt line with pull-up.
  logic       int_o;
  logic       int_oe;
  logic       int_n;

  assign int_n = (int_oe && !int_o) ? 1'b0 : 1'b1;

  modport host (
    output start, stop, wr, rd, wdata,
    input  ack_valid, ack, rvalid, rdata, int_n
  );
  modport dev (
    input  start, stop, wr, rd, wdata,
    output ack_valid, ack, rvalid, rdata, int_o, int_oe
  );
endinterface
`default_nettype wire

/* pxs_sensor_regs.sv */
// Sensor end: interrupt status, modulator timing and register read port.
//
// Behaviour
// - Status register holds four interrupt flags.
// - Flags stay set until written with one.
// - Interrupt pin low while any flag set.
// - Timing register: delay, frequency, dead time.
// - Delay field compensates emitter delay, resets zero.
// - Host should program timing register with one.
// - Host should not use ambient IR register.
// - No measurement requested means standby.
// - Standby keeps emitter current sink off.
// - Pointer write first, then read returns register.
// - Stop plus start or repeated start accepted.
// - Pointer increments after each read byte.
`default_nettype none
module pxs_sensor_regs (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         arst_n,
  // Link to the host controller
  pxs_link_if.dev                           link,
  // Events from the measurement engines
  input  wire logic                         prox_ready_evt,
  input  wire logic                         als_ready_evt,
  input  wire logic                         below_limit_evt,
  input  wire logic                         above_limit_evt,
  // Measurement demand and emitter drive request
  input  wire logic                         prox_req,
  input  wire logic                         als_req,
  input  wire logic                         emitter_drive,
  // Raw ambient IR level for the reserved register
  input  wire logic [7:0]                   ambient_ir,
  // Timing fields to the modulator
  output logic [pxs_pkg::PXS_DLY_W-1:0]     mod_delay,
  output logic [pxs_pkg::PXS_FRQ_W-1:0]     prox_freq,
  output logic [pxs_pkg::PXS_DEAD_W-1:0]    dead_time,
  // Power state and emitter sink
  output logic                              standby,
  output logic                              emitter_sink_en
);
  import pxs_pkg::*;

  // ==========================================================================
  // State
  // Link phases: IDLE ignores bytes until a start, ADDR checks the address
  // byte, PTR takes the register pointer, DATA writes bytes at the pointer
  // and READ answers read requests from it. A foreign address byte drops
  // back to IDLE, so the device stays quiet until the next start.
  typedef enum {
    PXS_PH_IDLE,
    PXS_PH_ADDR,
    PXS_PH_PTR,
    PXS_PH_DATA,
    PXS_PH_READ
  } pxs_phase_t;

  typedef struct packed {
    pxs_phase_t          phase;
    logic [7:0]          ptr;
    logic [PXS_ST_W-1:0] status;
    logic [7:0]          modtim;
    logic                ack_valid;
    logic                ack;
    logic                rvalid;
    logic [7:0]          rdata;
    logic                standby;
    logic                sink_en;
  } pxs_dev_state_t;

  pxs_dev_state_t s;
  pxs_dev_state_t next_s;

  // ==========================================================================
  // Helpers
  // The pointer wraps from the top of its 8-bit range back to zero.
  function automatic logic [7:0] ptr_step(input logic [7:0] ptr);
    return ptr + 8'h01;
  endfunction

  // Events are merged after the clear, so a set that lands in the clearing
  // cycle keeps its flag.
  function automatic logic [PXS_ST_W-1:0] flags_merge(input logic [PXS_ST_W-1:0] cur,
                                                      input logic [PXS_ST_W-1:0] clr,
                                                      input logic [PXS_ST_W-1:0] evt);
    return (cur & ~clr) | evt;
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    logic [PXS_ST_W-1:0] evt;
    logic [PXS_ST_W-1:0] clr;
    evt = '0;
    clr = '0;
    next_s = s;
    next_s.ack_valid = 1'b0;
    next_s.ack = 1'b0;
    next_s.rvalid = 1'b0;

    // One event pulse per flag from the measurement engines.
    evt[PXS_ST_PROX]  = prox_ready_evt;
    evt[PXS_ST_ALS]   = als_ready_evt;
    evt[PXS_ST_BELOW] = below_limit_evt;
    evt[PXS_ST_ABOVE] = above_limit_evt;

    // A start, repeated or not, always reopens the address phase.
    if (link.start) begin
      next_s.phase = PXS_PH_ADDR;
    end else if (link.stop) begin
      // The pointer survives a stop so a later read uses it.
      next_s.phase = PXS_PH_IDLE;
    end else if (link.wr) begin
      unique case (s.phase)
        PXS_PH_ADDR: begin
          next_s.ack_valid = 1'b1;
          if (link.wdata == pxs_addr_byte(PXS_RW_WRITE)) begin
            next_s.ack = 1'b1;
            next_s.phase = PXS_PH_PTR;
          end else if (link.wdata == pxs_addr_byte(PXS_RW_READ)) begin
            next_s.ack = 1'b1;
            next_s.phase = PXS_PH_READ;
          end else begin
            // A foreign address is refused with ack low.
            next_s.phase = PXS_PH_IDLE;
          end
        end
        PXS_PH_PTR: begin
          // The byte after the write address byte is always the pointer.
          next_s.ack_valid = 1'b1;
          next_s.ack = 1'b1;
          next_s.ptr = link.wdata;
          next_s.phase = PXS_PH_DATA;
        end
        PXS_PH_DATA: begin
          next_s.ack_valid = 1'b1;
          next_s.ack = 1'b1;
          if (s.ptr == PXS_OFS_STATUS) begin
            // Upper bits of the written byte are ignored.
            clr = link.wdata[PXS_ST_W-1:0];
          end else if (s.ptr == PXS_OFS_MODTIM) begin
            next_s.modtim = link.wdata;
          end
          // Writes at the reserved and unmapped offsets are dropped.
          next_s.ptr = ptr_step(s.ptr);
        end
        default: begin
          next_s.phase = s.phase;
        end
      endcase
    end else if (link.rd && s.phase == PXS_PH_READ) begin
      // Reads outside the read phase are ignored.
      next_s.rdata = pxs_read_reg(s.ptr, s.status, s.modtim, ambient_ir);
      next_s.rvalid = 1'b1;
      next_s.ptr = ptr_step(s.ptr);
    end

    next_s.status = flags_merge(s.status, clr, evt);

    // Only proximity demand may drive the emitter; with no demand at all the
    // block sits in standby and the sink is held off whatever is requested.
    next_s.standby = !(prox_req || als_req);
    next_s.sink_en = emitter_drive && prox_req && !next_s.standby;
  end

  // ==========================================================================
  // Registers
  // Only constants are loaded on reset; every other update passes through next_s.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s.phase     <= PXS_PH_IDLE;
      s.ptr       <= 8'h00;
      s.status    <= PXS_STATUS_RST;
      // Timing resets to zero delay, frequency zero and dead time one.
      s.modtim    <= PXS_MODTIM_RST;
      s.ack_valid <= 1'b0;
      s.ack       <= 1'b0;
      s.rvalid    <= 1'b0;
      s.rdata     <= 8'h00;
      s.standby   <= 1'b1;
      s.sink_en   <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  // Link answers leave straight from flip-flops, one cycle after the request.
  assign link.ack_valid = s.ack_valid;
  assign link.ack       = s.ack;
  assign link.rvalid    = s.rvalid;
  assign link.rdata     = s.rdata;

  // The pin only ever pulls low; the pull-up releases it.
  assign link.int_o  = 1'b0;
  assign link.int_oe = |s.status;

  // The timing fields are plain slices of the one register.
  assign mod_delay = s.modtim[PXS_DLY_LSB +: PXS_DLY_W];
  assign prox_freq = s.modtim[PXS_FRQ_LSB +: PXS_FRQ_W];
  assign dead_time = s.modtim[PXS_DEAD_LSB +: PXS_DEAD_W];

  assign standby         = s.standby;
  assign emitter_sink_en = s.sink_en;
endmodule
`default_nettype wire

/* pxs_host_ctrl.sv */
// Host end: sequences register writes and reads over the sensor link.
`default_nettype none
module pxs_host_ctrl (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Link to the sensor
  pxs_link_if.host        link,
  // Command port
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_write,
  input  wire logic       cmd_rep_start,
  input  wire logic [7:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  // Response port
  output logic            rsp_done,
  output logic            rsp_err,
  output logic [7:0]      rsp_data,
  // Interrupt seen on the link
  output logic            irq_active
);
  import pxs_pkg::*;

  // ==========================================================================
  // State
  typedef enum {
    PXS_H_IDLE,
    PXS_H_START,
    PXS_H_SEND,
    PXS_H_ACK,
    PXS_H_MIDSTOP,
    PXS_H_RESTART,
    PXS_H_READ,
    PXS_H_WAITRD,
    PXS_H_STOP
  } pxs_hstate_t;

  typedef struct packed {
    pxs_hstate_t st;
    logic [1:0]  step;
    logic        init;
    logic        user;
    logic        write;
    logic        rep;
    logic [7:0]  addr;
    logic [7:0]  data;
    logic [7:0]  txb;
    logic        done;
    logic        err;
    logic [7:0]  rdata;
    logic        irq;
  } pxs_host_state_t;

  pxs_host_state_t s;
  pxs_host_state_t next_s;

  // ==========================================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.irq = !link.int_n;
    unique case (s.st)
      PXS_H_IDLE: begin
        if (s.init) begin
          // Program the timing register with its default after reset.
          next_s.init = 1'b0;
          next_s.user = 1'b0;
          next_s.write = 1'b1;
          next_s.addr = PXS_OFS_MODTIM;
          next_s.data = PXS_MODTIM_RST;
          next_s.st = PXS_H_START;
        end else if (cmd_valid) begin
          next_s.user = 1'b1;
          next_s.write = cmd_write;
          next_s.rep = cmd_rep_start;
          next_s.addr = cmd_addr;
          next_s.data = cmd_wdata;
          next_s.err = 1'b0;
          if (cmd_addr == PXS_OFS_AMBIR) begin
            next_s.err = 1'b1;
            next_s.done = 1'b1;
          end else begin
            next_s.st = PXS_H_START;
          end
        end
      end
      PXS_H_START: begin
        next_s.step = 2'h0;
        next_s.txb = pxs_addr_byte(PXS_RW_WRITE);
        next_s.st = PXS_H_SEND;
      end
      PXS_H_SEND: begin
        next_s.st = PXS_H_ACK;
      end
      PXS_H_ACK: begin
        if (link.ack_valid) begin
          if (!link.ack) begin
            next_s.err = 1'b1;
            next_s.st = PXS_H_STOP;
          end else if (s.step == 2'h0) begin
            next_s.step = 2'h1;
            next_s.txb = s.addr;
            next_s.st = PXS_H_SEND;
          end else if (s.step == 2'h1 && s.write) begin
            next_s.step = 2'h2;
            next_s.txb = s.data;
            next_s.st = PXS_H_SEND;
          end else if (s.step == 2'h1) begin
            next_s.st = s.rep ? PXS_H_RESTART : PXS_H_MIDSTOP;
          end else if (s.step == 2'h3) begin
            next_s.st = PXS_H_READ;
          end else begin
            next_s.st = PXS_H_STOP;
          end
        end
      end
      PXS_H_MIDSTOP: begin
        next_s.st = PXS_H_RESTART;
      end
      PXS_H_RESTART: begin
        next_s.step = 2'h3;
        next_s.txb = pxs_addr_byte(PXS_RW_READ);
        next_s.st = PXS_H_SEND;
      end
      PXS_H_READ: begin
        next_s.st = PXS_H_WAITRD;
      end
      PXS_H_WAITRD: begin
        if (link.rvalid) begin
          next_s.rdata = link.rdata;
          next_s.st = PXS_H_STOP;
        end
      end
      PXS_H_STOP: begin
        next_s.done = s.user;
        next_s.st = PXS_H_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s.st    <= PXS_H_IDLE;
      s.step  <= 2'h0;
      s.init  <= 1'b1;
      s.user  <= 1'b0;
      s.write <= 1'b0;
      s.rep   <= 1'b0;
      s.addr  <= 8'h00;
      s.data  <= 8'h00;
      s.txb   <= 8'h00;
      s.done  <= 1'b0;
      s.err   <= 1'b0;
      s.rdata <= 8'h00;
      s.irq   <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  assign link.start = (s.st == PXS_H_START) || (s.st == PXS_H_RESTART);
  assign link.stop  = (s.st == PXS_H_STOP) || (s.st == PXS_H_MIDSTOP);
  assign link.wr    = (s.st == PXS_H_SEND);
  assign link.rd    = (s.st == PXS_H_READ);
  assign link.wdata = s.txb;

  assign cmd_ready  = (s.st == PXS_H_IDLE) && !s.init;
  assign rsp_done   = s.done;
  assign rsp_err    = s.err;
  assign rsp_data   = s.rdata;
  assign irq_active = s.irq;
endmodule
`default_nettype wire

/* pxs_link_props.sv */
// Concurrent checks on the link between the host and sensor ends.
`default_nettype none
module pxs_link_props (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       arst_n,
  // Host to device
  input wire logic       start,
  input wire logic       stop,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] wdata,
  // Device to host
  input wire logic       ack_valid,
  input wire logic       ack,
  input wire logic       rvalid,
  input wire logic [7:0] rdata,
  input wire logic       int_o,
  input wire logic       int_oe,
  input wire logic       int_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import pxs_pkg::*;
  // ==========================================================================
  // Link answers
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_wr_gets_ack: assert property (wr |=> ack_valid)
    else $error("write byte not answered");
  a_ack_has_cause: assert property (ack_valid |-> $past(wr))
    else $error("answer without write byte");
  a_rd_gets_byte: assert property (rd |=> rvalid)
    else $error("read request not answered");
  a_byte_has_cause: assert property (rvalid |-> $past(rd))
    else $error("read byte without request");
  a_rdata_held: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved between reads");
  a_answer_alone: assert property (!(ack_valid && rvalid))
    else $error("two answers in one cycle");
  a_addr_acked: assert property (ack_valid && $past(start, 2) |->
    ack == (($past(wdata) | 8'h01) == {PXS_DEV_ADDR, 1'b1}))
    else $error("address byte answer wrong");
  // ==========================================================================
  // Interrupt pin
  a_pin_pulled: assert property (int_oe |-> !int_n)
    else $error("pin not low while driven");
  a_pin_released: assert property (!int_oe |-> int_n)
    else $error("pin low while released");
  a_pin_low_only: assert property (int_o == 1'b0)
    else $error("pin driven high");
  a_flag_held: assert property ($fell(int_oe) |-> $past(wr) || $past(wr, 2))
    else $error("flag dropped without write");
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench joining the host and sensor ends over the link.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pxs_pkg::*;
  logic       ref_clk;
  logic       arst_n;
  logic [3:0] ev;
  logic       prox_req, als_req, emitter_drive;
  logic       cmd_valid, cmd_write, cmd_rep_start;
  logic [7:0] cmd_addr, cmd_wdata, ambient_ir, rsp_data;
  logic       cmd_ready, rsp_done, rsp_err, irq_active, standby, emitter_sink_en;
  logic [2:0] mod_delay, dead_time;
  logic [1:0] prox_freq;
  int         mismatches, compares;

  pxs_link_if link ();
  pxs_sensor_regs pxs_sensor_regs_inst (.ref_clk, .arst_n, .link,
    .prox_ready_evt(ev[3]), .als_ready_evt(ev[2]), .below_limit_evt(ev[1]),
    .above_limit_evt(ev[0]), .prox_req, .als_req, .emitter_drive, .ambient_ir,
    .mod_delay, .prox_freq, .dead_time, .standby, .emitter_sink_en);
  pxs_host_ctrl pxs_host_ctrl_inst (.ref_clk, .arst_n, .link, .cmd_valid, .cmd_ready,
    .cmd_write, .cmd_rep_start, .cmd_addr, .cmd_wdata, .rsp_done, .rsp_err,
    .rsp_data, .irq_active);
  pxs_link_props pxs_link_props_inst (.ref_clk, .arst_n, .start(link.start),
    .stop(link.stop), .wr(link.wr), .rd(link.rd), .wdata(link.wdata),
    .ack_valid(link.ack_valid), .ack(link.ack), .rvalid(link.rvalid),
    .rdata(link.rdata), .int_o(link.int_o), .int_oe(link.int_oe), .int_n(link.int_n));

  always #5 ref_clk = ~ref_clk;

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input logic w, input logic r, input logic [7:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 60) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    @(posedge ref_clk);
    cmd_valid     <= 1'b1;
    cmd_write     <= w;
    cmd_rep_start <= r;
    cmd_addr      <= a;
    cmd_wdata     <= d;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1;
    n = 0;
    while (rsp_done !== 1'b1 && n < 60) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 60) chk(8'h00, 8'h01);
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 4'h0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    logic [7:0] d;
    ref_clk = 1'b0;
    arst_n = 1'b0;
    ev = 4'h0;
    {prox_req, als_req, emitter_drive, cmd_valid, cmd_write, cmd_rep_start} = '0;
    cmd_addr = 8'h00;
    cmd_wdata = 8'h00;
    ambient_ir = 8'h5a;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    cmd(1'b0, 1'b1, PXS_OFS_MODTIM, 8'h00);
    chk(rsp_data, PXS_MODTIM_RST);
    chk({7'h00, rsp_err}, 8'h00);
    chk({5'h00, mod_delay}, 8'h00);
    chk({5'h00, dead_time}, 8'h01);
    cmd(1'b0, 1'b0, PXS_OFS_STATUS, 8'h00);
    chk(rsp_data, 8'h00);
    $display("test reset_values finished");
    for (int f = 0; f < 4; f++) begin
      d = {3'h5, f[1:0], 3'h6};
      cmd(1'b1, 1'b0, PXS_OFS_MODTIM, d);
      cmd(1'b0, f[0], PXS_OFS_MODTIM, 8'h00);
      chk(rsp_data, d);
      chk({6'h00, prox_freq}, {6'h00, d[4:3]});
      chk({5'h00, mod_delay}, 8'h05);
      chk({5'h00, dead_time}, 8'h06);
    end
    cmd(1'b1, 1'b0, PXS_OFS_MODTIM, PXS_MODTIM_RST);
    cmd(1'b0, 1'b1, PXS_OFS_AMBIR, 8'h00);
    chk({7'h00, rsp_err}, 8'h01);
    $display("test timing_fields finished");
    pulse(4'hf);
    cmd(1'b0, 1'b1, PXS_OFS_STATUS, 8'h00);
    chk(rsp_data, 8'h0f);
    chk({7'h00, rsp_err}, 8'h00);
    chk({7'h00, link.int_n}, 8'h00);
    chk({7'h00, irq_active}, 8'h01);
    cmd(1'b1, 1'b0, PXS_OFS_STATUS, 8'h05);
    cmd(1'b0, 1'b0, PXS_OFS_STATUS, 8'h00);
    chk(rsp_data, 8'h0a);
    // The event is raised only in the cycle whose closing edge applies the clear.
    fork
      cmd(1'b1, 1'b0, PXS_OFS_STATUS, 8'h0a);
      begin
        repeat (7) @(posedge ref_clk);
        ev <= 4'h8;
        @(posedge ref_clk);
        ev <= 4'h0;
      end
    join
    cmd(1'b0, 1'b1, PXS_OFS_STATUS, 8'h00);
    chk(rsp_data, 8'h08);
    cmd(1'b1, 1'b0, PXS_OFS_STATUS, 8'hff);
    cmd(1'b0, 1'b1, PXS_OFS_STATUS, 8'h00);
    chk(rsp_data, 8'h00);
    chk({7'h00, link.int_n}, 8'h01);
    chk({7'h00, irq_active}, 8'h00);
    $display("test status_flags finished");
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      prox_req <= i[1];
      als_req <= i[0];
      emitter_drive <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      chk({7'h00, standby}, {7'h00, i == 0});
      chk({7'h00, emitter_sink_en}, {7'h00, i[1]});
    end
    $display("test standby finished");
    print_verdict();
  end

  initial begin
    #50000;
    chk(8'h00, 8'h01);
    print_verdict();
  end
endmodule
`default_nettype wire
